/* sim/scan_probe_model.sv */
`timescale 1ns/1ps
module scan_probe_model (
	input wire logic i_tdo,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	output logic o_trst_n,
	output logic o_reset_pin
);
	initial begin
		o_tck = 1'h0;
		o_tms = 1'h1;
		o_tdi = 1'h1;
		o_trst_n = 1'h1;
		o_reset_pin = 1'h1;
	end
	// clock stands low between frames; lines fall back to their pull-up level
	// never used in deep-sleep or power-down states
	// bootloader entry pin is not modelled and never held low here
	// 200 ns bit; edges kept off the system clock edges to avoid races
	task tck_bit(input logic tms, input logic tdi);
		o_tms = tms;
		o_tdi = tdi;
		#37 o_tck = 1'h1;
		#100 o_tck = 1'h0;
		#63 o_tms = 1'h1;
		o_tdi = 1'h1;
	endtask : tck_bit
	task nav(input logic [7:0] seq, input int n);
		for (int i = 0; i < n; i++) tck_bit(seq[i], 1'h1);
	endtask : nav
	task shift(input logic [7:0] din, input int n, output logic [7:0] dout);
		dout = 8'h00;
		for (int i = 0; i < n; i++) begin
			o_tms = (i == n - 1);
			o_tdi = din[i];
			// sampled just before the rise, well after the output settled on the fall
			#37 dout[i] = i_tdo;
			o_tck = 1'h1;
			#100 o_tck = 1'h0;
			#63 o_tms = 1'h1;
			o_tdi = 1'h1;
		end
	endtask : shift
	task hold_trst(input logic v);
		o_trst_n = v;
	endtask : hold_trst
	task enter_scan;
		o_reset_pin = 1'h1;
		#1000000 o_reset_pin = 1'h0;
	endtask : enter_scan
	task exit_scan;
		hold_trst(1'h0);
		#500 o_reset_pin = 1'h1;
		#500 hold_trst(1'h1);
	endtask : exit_scan
endmodule : scan_probe_model

/* sim/swd_jtag_test_port_select_asserts.sv */
`timescale 1ns/1ps
module swd_jtag_test_port_select_asserts #(
	parameter int NUM_BP = 4,
	parameter int ADDR_W = 32
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_tck_swclk,
	input wire logic i_dbg_swdio_oe,
	input wire logic i_debug_session,
	input wire logic i_core_halted,
	input wire logic [ADDR_W-1:0] i_pc,
	input wire logic [NUM_BP-1:0][ADDR_W-1:0] i_bp_addr,
	input wire logic [NUM_BP-1:0] i_bp_en,
	input wire logic o_tdo,
	input wire logic o_tdo_oe,
	input wire logic o_swdio_oe,
	input wire logic o_swclk_rise,
	input wire logic o_pullup_en,
	input wire logic o_swclk_func_en,
	input wire logic o_swdio_func_en,
	input wire logic o_jtag_mode,
	input wire logic o_swd_mode,
	input wire logic o_core_dbg_access_en,
	input wire logic o_bsr_drive,
	input wire logic o_systick_halt,
	input wire logic [NUM_BP-1:0] o_bp_hit
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	sequence swclk_pulse;
		o_swclk_rise ##1 !o_swclk_rise;
	endsequence
	a_mode_exclusive: assert property (o_jtag_mode != o_swd_mode)
		else $error("scan and debug modes not exclusive");
	a_no_jtag_debug: assert property (o_core_dbg_access_en == o_swd_mode)
		else $error("core debug access outside debug mode");
	a_pullup_held: assert property (o_pullup_en)
		else $error("pull-up dropped");
	a_systick_follow: assert property (
		o_systick_halt == $past(o_swd_mode && i_debug_session && i_core_halted))
		else $error("tick timer halt wrong");
	a_swdio_oe_src: assert property (o_swdio_oe |-> $past(i_dbg_swdio_oe))
		else $error("swdio driven without request");
	a_oe_off_swd: assert property (o_swd_mode |=> !o_tdo_oe)
		else $error("scan output on in debug mode");
	a_swclk_once: assert property (o_swclk_rise |-> swclk_pulse)
		else $error("swclk pulse bad");
	a_swclk_gate: assert property (o_swclk_rise |-> o_swclk_func_en)
		else $error("swclk pulse while function disabled");
	a_bsr_jtag: assert property (o_bsr_drive |-> o_jtag_mode)
		else $error("scan pins driven outside scan mode");
	a_func_swd: assert property ((o_swclk_func_en || o_swdio_func_en) |-> o_swd_mode)
		else $error("debug pin function on in scan mode");
	a_bp_hit_last: assert property (
		o_bp_hit[NUM_BP-1] == $past(i_bp_en[NUM_BP-1] && i_pc == i_bp_addr[NUM_BP-1]))
		else $error("breakpoint hit wrong");
	a_tdo_on_fall: assert property (
		$changed(o_tdo) |-> !$past(i_tck_swclk) && !$past(i_tck_swclk, 2))
		else $error("scan output moved off falling edge");
endmodule : swd_jtag_test_port_select_asserts

bind swd_jtag_test_port_select swd_jtag_test_port_select_asserts #(
	.NUM_BP(NUM_BP), .ADDR_W(ADDR_W)) u_chk (.i_sys_clk, .i_nrst, .i_tck_swclk,
	.i_dbg_swdio_oe, .i_debug_session, .i_core_halted, .i_pc, .i_bp_addr, .i_bp_en, .o_tdo,
	.o_tdo_oe, .o_swdio_oe, .o_swclk_rise, .o_pullup_en, .o_swclk_func_en, .o_swdio_func_en,
	.o_jtag_mode, .o_swd_mode, .o_core_dbg_access_en, .o_bsr_drive, .o_systick_halt, .o_bp_hit);

/* sim/swd_jtag_test_port_select_tb.sv */
`timescale 1ns/1ps
module swd_jtag_test_port_select_tb;
	logic i_sys_clk, i_nrst, i_por_evt, i_brownout_evt, i_dbg_swdio_out, i_dbg_swdio_oe;
	logic i_pin_enable_wr, i_debug_session, i_core_halted, i_data_access;
	logic [1:0] i_pin_enable_data, i_wp_en, i_wp_trig_en, o_wp_hit, o_wp_trigger;
	logic [7:0] i_bsr_pins, o_bsr_pins;
	logic [31:0] i_pc, i_data_addr;
	logic [3:0][31:0] i_bp_addr;
	logic [1:0][31:0] i_wp_addr;
	logic [3:0] i_bp_en, o_bp_hit;
	logic o_tdo, o_tdo_oe, o_swdio_out, o_swdio_oe, o_swclk_rise, o_pullup_en, o_swclk_func_en;
	logic o_swdio_func_en, o_jtag_mode, o_swd_mode, o_core_dbg_access_en, o_bsr_drive;
	logic o_systick_halt, i_tck_swclk, i_tms_swdio, i_tdi, i_trst_n, i_reset_pin;
	logic o_swdio_in;
	int errors, compares, rises;
	swd_jtag_test_port_select u_dut (.i_sys_clk, .i_nrst, .i_reset_pin, .i_por_evt,
		.i_brownout_evt, .i_tck_swclk, .i_tms_swdio, .i_tdi, .i_trst_n, .o_tdo, .o_tdo_oe,
		.o_swdio_out, .o_swdio_oe, .o_swclk_rise, .o_swdio_in, .o_pullup_en,
		.i_dbg_swdio_out, .i_dbg_swdio_oe, .i_pin_enable_wr, .i_pin_enable_data,
		.o_swclk_func_en, .o_swdio_func_en, .o_jtag_mode, .o_swd_mode, .o_core_dbg_access_en,
		.i_bsr_pins, .o_bsr_pins, .o_bsr_drive, .i_debug_session, .i_core_halted,
		.o_systick_halt, .i_pc, .i_bp_addr, .i_bp_en, .i_data_addr, .i_data_access,
		.i_wp_addr, .i_wp_en, .i_wp_trig_en, .o_bp_hit, .o_wp_hit, .o_wp_trigger);
	scan_probe_model u_probe (.i_tdo(o_tdo), .o_tck(i_tck_swclk), .o_tms(i_tms_swdio),
		.o_tdi(i_tdi), .o_trst_n(i_trst_n), .o_reset_pin(i_reset_pin));
	initial begin
		i_sys_clk = 1'h0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) rises <= rises + (o_swclk_rise === 1'h1);
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task pin_en(input logic [1:0] v);
		@(posedge i_sys_clk) i_pin_enable_wr <= 1'h1;
		i_pin_enable_data <= v;
		@(posedge i_sys_clk) i_pin_enable_wr <= 1'h0;
		@(negedge i_sys_clk);
	endtask : pin_en
	task t_swd;
		repeat (4) @(negedge i_sys_clk);
		check({o_jtag_mode, o_swd_mode, o_core_dbg_access_en}, 3'h3);
		check({o_swdio_func_en, o_swclk_func_en, o_pullup_en}, 3'h7);
		check(o_swdio_in, 1'h1);
		@(posedge i_sys_clk) i_dbg_swdio_oe <= 1'h1;
		i_dbg_swdio_out <= 1'h1;
		repeat (2) @(negedge i_sys_clk);
		check({o_swdio_oe, o_swdio_out}, 2'h3);
		rises = 0;
		u_probe.nav(8'hFF, 2);
		check(rises, 32'h2);
		pin_en(2'h0);
		@(negedge i_sys_clk) check({o_swdio_func_en, o_swclk_func_en, o_swdio_oe}, 3'h0);
		rises = 0;
		u_probe.nav(8'hFF, 2);
		check(rises, 32'h0);
		pin_en(2'h3);
	endtask : t_swd
	task t_systick;
		@(posedge i_sys_clk) i_debug_session <= 1'h1;
		i_core_halted <= 1'h1;
		@(negedge i_sys_clk) @(negedge i_sys_clk) check(o_systick_halt, 1'h1);
		@(posedge i_sys_clk) i_core_halted <= 1'h0;
		@(negedge i_sys_clk) @(negedge i_sys_clk) check(o_systick_halt, 1'h0);
	endtask : t_systick
	task t_break;
		@(posedge i_sys_clk) i_bp_addr[3] <= 32'h00000100;
		i_bp_en <= 4'h8;
		i_pc <= 32'h00000100;
		i_wp_addr[1] <= 32'h00000200;
		i_wp_en <= 2'h2;
		i_wp_trig_en <= 2'h2;
		i_data_addr <= 32'h00000200;
		i_data_access <= 1'h1;
		@(negedge i_sys_clk) @(negedge i_sys_clk) check({o_bp_hit, o_wp_hit, o_wp_trigger}, 8'h8A);
	endtask : t_break
	task load_ir(input logic [3:0] ir);
		logic [7:0] d;
		u_probe.nav(8'h06, 5);
		u_probe.shift({4'h0, ir}, 4, d);
		check(d[3:0], 4'h1);
		u_probe.nav(8'h01, 2);
	endtask : load_ir
	task t_scan;
		logic [7:0] d;
		u_probe.enter_scan();
		repeat (3) @(negedge i_sys_clk);
		check({o_jtag_mode, o_swd_mode, o_core_dbg_access_en, o_swclk_func_en}, 4'h8);
		load_ir(4'h0);
		u_probe.nav(8'h01, 3);
		u_probe.shift(8'h3C, 8, d);
		check(d, 8'hA5);
		u_probe.nav(8'h01, 2);
		check({o_bsr_drive, o_bsr_pins}, 9'h13C);
		for (int k = 0; k < 3; k++) begin
			load_ir(4'h0);
			check(o_bsr_drive, 1'h1);
			@(posedge i_sys_clk) i_por_evt <= (k == 0);
			i_brownout_evt <= (k == 1);
			if (k == 2) u_probe.hold_trst(1'h0);
			repeat (4) @(negedge i_sys_clk);
			check(o_bsr_drive, 1'h0);
			@(posedge i_sys_clk) i_por_evt <= 1'h0;
			i_brownout_evt <= 1'h0;
			u_probe.hold_trst(1'h1);
		end
		u_probe.exit_scan();
		u_probe.nav(8'hFF, 1);
		check({o_swd_mode, o_tdo_oe, o_bsr_drive}, 3'h4);
	endtask : t_scan
	task end_of_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		{errors, compares, rises} = '0;
		{i_nrst, i_por_evt, i_brownout_evt, i_dbg_swdio_out, i_dbg_swdio_oe} = '0;
		{i_pin_enable_wr, i_pin_enable_data, i_debug_session, i_core_halted} = '0;
		{i_pc, i_bp_addr, i_bp_en, i_data_addr, i_data_access} = '0;
		{i_wp_addr, i_wp_en, i_wp_trig_en} = '0;
		i_bsr_pins = 8'hA5;
		repeat (3) @(posedge i_sys_clk);
		i_nrst <= 1'h1;
		t_swd();
		t_systick();
		t_break();
		t_scan();
		end_of_test();
	end
	initial begin
		#2000000 errors++;
		end_of_test();
	end
endmodule : swd_jtag_test_port_select_tb

/* verilog/swd_jtag_params.svh */
`ifndef SWD_JTAG_PARAMS_SVH
`define SWD_JTAG_PARAMS_SVH

// instruction register width and opcodes
`define SWJ_IR_W 4
`define SWJ_IR_EXTEST 4'h0
`define SWJ_IR_SAMPLE 4'h1
`define SWJ_IR_BYPASS 4'hF
// value loaded into the instruction shifter in Capture-IR
`define SWJ_IR_CAPTURE 4'h1
// reset value of the fixed pin enables: swclk and swdio both enabled
`define SWJ_PIN_EN_RESET 2'h3
`define SWJ_PIN_EN_W 2
`define SWJ_PIN_SWCLK 0
`define SWJ_PIN_SWDIO 1

`endif

/* verilog/swd_jtag_pkg.sv */
package swd_jtag_pkg;

	typedef enum logic [3:0] {
		TLR,
		RTI,
		SEL_DR,
		CAP_DR,
		SHIFT_DR,
		EXIT1_DR,
		PAUSE_DR,
		EXIT2_DR,
		UPD_DR,
		SEL_IR,
		CAP_IR,
		SHIFT_IR,
		EXIT1_IR,
		PAUSE_IR,
		EXIT2_IR,
		UPD_IR
	} tap_state_t;

endpackage : swd_jtag_pkg

/* verilog/swd_jtag_test_port_select.sv */
// Operation
// - reset pin low selects boundary scan, reset pin high selects serial wire debug
// - serial wire debug port stays disabled while the part is held in reset
// - each scan output bit is driven on the falling test clock edge
// - tap next state follows sampled tms; tap used only while reset pin low
// - power-on, brownout or trst low force the tap into Test-Logic-Reset
// - first test clock edge with reset pin high moves tap to Run-Test/Idle
// - system tick timer halts with the halted core during debug; others run
// - swclk and swdio functions enabled after reset; pin enable register can disable
// - four hardware breakpoints, two data watchpoints, watchpoints usable as triggers
// - jtag port gives boundary scan only, never core debug access
// - hardware selects scan pins; routing matrix cannot reassign or reach them
// - tdi feeds the scan shift register input and is pulled up
// - debug logic clocked from swclk, talks over swdio; both lines pulled up
`timescale 1ns/1ps
`include "swd_jtag_params.svh"

module swd_jtag_test_port_select #(
	parameter int BSR_LEN = 8,
	parameter int NUM_BP = 4,
	parameter int NUM_WP = 2,
	parameter int ADDR_W = 32
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_reset_pin,
	input wire logic i_por_evt,
	input wire logic i_brownout_evt,
	input wire logic i_tck_swclk,
	input wire logic i_tms_swdio,
	input wire logic i_tdi,
	input wire logic i_trst_n,
	output logic o_tdo,
	output logic o_tdo_oe,
	output logic o_swdio_out,
	output logic o_swdio_oe,
	output logic o_swclk_rise,
	output logic o_swdio_in,
	output logic o_pullup_en,
	input wire logic i_dbg_swdio_out,
	input wire logic i_dbg_swdio_oe,
	input wire logic i_pin_enable_wr,
	input wire logic [`SWJ_PIN_EN_W-1:0] i_pin_enable_data,
	output logic o_swclk_func_en,
	output logic o_swdio_func_en,
	output logic o_jtag_mode,
	output logic o_swd_mode,
	output logic o_core_dbg_access_en,
	input wire logic [BSR_LEN-1:0] i_bsr_pins,
	output logic [BSR_LEN-1:0] o_bsr_pins,
	output logic o_bsr_drive,
	input wire logic i_debug_session,
	input wire logic i_core_halted,
	output logic o_systick_halt,
	input wire logic [ADDR_W-1:0] i_pc,
	input wire logic [NUM_BP-1:0][ADDR_W-1:0] i_bp_addr,
	input wire logic [NUM_BP-1:0] i_bp_en,
	input wire logic [ADDR_W-1:0] i_data_addr,
	input wire logic i_data_access,
	input wire logic [NUM_WP-1:0][ADDR_W-1:0] i_wp_addr,
	input wire logic [NUM_WP-1:0] i_wp_en,
	input wire logic [NUM_WP-1:0] i_wp_trig_en,
	output logic [NUM_BP-1:0] o_bp_hit,
	output logic [NUM_WP-1:0] o_wp_hit,
	output logic [NUM_WP-1:0] o_wp_trigger
);

	//--------------------------------------------------------------
	// elaboration checks
	//--------------------------------------------------------------
	if (BSR_LEN < 1 || NUM_BP < 1 || NUM_WP < 1 || ADDR_W < 2) begin : g_bad_param
		$error("swd_jtag_test_port_select: unsupported parameter value");
	end

	//--------------------------------------------------------------
	// state
	//--------------------------------------------------------------
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic tck_s1;
		logic tck_s2;
		logic tck_s3;
		logic tms_s1;
		logic tms_s2;
		logic tdi_s1;
		logic tdi_s2;
		logic trst_s1;
		logic trst_s2;
		swd_jtag_pkg::tap_state_t tap;
		logic [`SWJ_IR_W-1:0] ir;
		logic [`SWJ_IR_W-1:0] ir_shift;
		logic [BSR_LEN-1:0] bsr_shift;
		logic [BSR_LEN-1:0] bsr_out;
		logic bypass;
		logic tdo;
		logic tdo_oe;
		logic swdio_out;
		logic swdio_oe;
		logic [`SWJ_PIN_EN_W-1:0] pin_en;
		logic systick_halt;
		logic [NUM_BP-1:0] bp_hit;
		logic [NUM_WP-1:0] wp_hit;
		logic [NUM_WP-1:0] wp_trig;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic tck_rise;
	logic tck_fall;
	logic jtag_sel;
	logic tap_reset;
	logic sel_bsr;
	logic [NUM_BP-1:0] bp_match;
	logic [NUM_WP-1:0] wp_match;

	//--------------------------------------------------------------
	// comparators
	//--------------------------------------------------------------
	for (genvar gi = 0; gi < NUM_BP; gi++) begin : g_bp
		assign bp_match[gi] = i_bp_en[gi] && (i_pc == i_bp_addr[gi]);
	end
	for (genvar gi = 0; gi < NUM_WP; gi++) begin : g_wp
		assign wp_match[gi] = i_wp_en[gi] && i_data_access
			&& (i_data_addr == i_wp_addr[gi]);
	end

	//--------------------------------------------------------------
	// tap next state
	//--------------------------------------------------------------
	function automatic swd_jtag_pkg::tap_state_t tap_step(
		input swd_jtag_pkg::tap_state_t s,
		input logic tms
	);
		swd_jtag_pkg::tap_state_t n;
		n = s;
		unique case (s)
			swd_jtag_pkg::TLR: n = tms ? swd_jtag_pkg::TLR : swd_jtag_pkg::RTI;
			swd_jtag_pkg::RTI: n = tms ? swd_jtag_pkg::SEL_DR : swd_jtag_pkg::RTI;
			swd_jtag_pkg::SEL_DR: n = tms ? swd_jtag_pkg::SEL_IR : swd_jtag_pkg::CAP_DR;
			swd_jtag_pkg::CAP_DR: n = tms ? swd_jtag_pkg::EXIT1_DR : swd_jtag_pkg::SHIFT_DR;
			swd_jtag_pkg::SHIFT_DR: n = tms ? swd_jtag_pkg::EXIT1_DR : swd_jtag_pkg::SHIFT_DR;
			swd_jtag_pkg::EXIT1_DR: n = tms ? swd_jtag_pkg::UPD_DR : swd_jtag_pkg::PAUSE_DR;
			swd_jtag_pkg::PAUSE_DR: n = tms ? swd_jtag_pkg::EXIT2_DR : swd_jtag_pkg::PAUSE_DR;
			swd_jtag_pkg::EXIT2_DR: n = tms ? swd_jtag_pkg::UPD_DR : swd_jtag_pkg::SHIFT_DR;
			swd_jtag_pkg::UPD_DR: n = tms ? swd_jtag_pkg::SEL_DR : swd_jtag_pkg::RTI;
			swd_jtag_pkg::SEL_IR: n = tms ? swd_jtag_pkg::TLR : swd_jtag_pkg::CAP_IR;
			swd_jtag_pkg::CAP_IR: n = tms ? swd_jtag_pkg::EXIT1_IR : swd_jtag_pkg::SHIFT_IR;
			swd_jtag_pkg::SHIFT_IR: n = tms ? swd_jtag_pkg::EXIT1_IR : swd_jtag_pkg::SHIFT_IR;
			swd_jtag_pkg::EXIT1_IR: n = tms ? swd_jtag_pkg::UPD_IR : swd_jtag_pkg::PAUSE_IR;
			swd_jtag_pkg::PAUSE_IR: n = tms ? swd_jtag_pkg::EXIT2_IR : swd_jtag_pkg::PAUSE_IR;
			swd_jtag_pkg::EXIT2_IR: n = tms ? swd_jtag_pkg::UPD_IR : swd_jtag_pkg::SHIFT_IR;
			swd_jtag_pkg::UPD_IR: n = tms ? swd_jtag_pkg::SEL_DR : swd_jtag_pkg::RTI;
		endcase
		return n;
	endfunction : tap_step

	//--------------------------------------------------------------
	// next-state logic
	//--------------------------------------------------------------
	// edges come from the second and third stages only, never the first
	assign tck_rise = state_reg.tck_s2 && !state_reg.tck_s3;
	assign tck_fall = !state_reg.tck_s2 && state_reg.tck_s3;
	assign jtag_sel = !state_reg.rst_s2;
	assign tap_reset = i_por_evt || i_brownout_evt || !state_reg.trst_s2;
	assign sel_bsr = (state_reg.ir == `SWJ_IR_EXTEST) || (state_reg.ir == `SWJ_IR_SAMPLE);

	always_comb begin
		state_next = state_reg;
		state_next.rst_s1 = i_reset_pin;
		state_next.rst_s2 = state_reg.rst_s1;
		state_next.tck_s1 = i_tck_swclk;
		state_next.tck_s2 = state_reg.tck_s1;
		state_next.tck_s3 = state_reg.tck_s2;
		state_next.tms_s1 = i_tms_swdio;
		state_next.tms_s2 = state_reg.tms_s1;
		state_next.tdi_s1 = i_tdi;
		state_next.tdi_s2 = state_reg.tdi_s1;
		state_next.trst_s1 = i_trst_n;
		state_next.trst_s2 = state_reg.trst_s1;

		if (tap_reset) begin
			state_next.tap = swd_jtag_pkg::TLR;
			state_next.ir = `SWJ_IR_BYPASS;
		end else if (tck_rise && !jtag_sel) begin
			state_next.tap = swd_jtag_pkg::RTI;
		end else if (tck_rise) begin
			state_next.tap = tap_step(state_reg.tap, state_reg.tms_s2);
			unique case (state_reg.tap)
				swd_jtag_pkg::TLR: state_next.ir = `SWJ_IR_BYPASS;
				swd_jtag_pkg::CAP_IR: state_next.ir_shift = `SWJ_IR_CAPTURE;
				swd_jtag_pkg::SHIFT_IR: state_next.ir_shift =
					{state_reg.tdi_s2, state_reg.ir_shift[`SWJ_IR_W-1:1]};
				swd_jtag_pkg::UPD_IR: state_next.ir = state_reg.ir_shift;
				swd_jtag_pkg::CAP_DR: begin
					state_next.bsr_shift = i_bsr_pins;
					state_next.bypass = 1'b0;
				end
				swd_jtag_pkg::SHIFT_DR: begin
					if (sel_bsr) begin
						if (BSR_LEN == 1) begin
							state_next.bsr_shift[0] = state_reg.tdi_s2;
						end else begin
							state_next.bsr_shift =
								{state_reg.tdi_s2, state_reg.bsr_shift[BSR_LEN-1:1]};
						end
					end else begin
						state_next.bypass = state_reg.tdi_s2;
					end
				end
				swd_jtag_pkg::UPD_DR: begin
					if (state_reg.ir == `SWJ_IR_EXTEST) begin
						state_next.bsr_out = state_reg.bsr_shift;
					end
				end
				default: begin
				end
			endcase
		end

		// output bit changes only on the falling edge so the tester samples it stable
		if (tck_fall) begin
			state_next.tdo_oe = jtag_sel && (state_reg.tap == swd_jtag_pkg::SHIFT_DR
				|| state_reg.tap == swd_jtag_pkg::SHIFT_IR);
			if (state_reg.tap == swd_jtag_pkg::SHIFT_IR) begin
				state_next.tdo = state_reg.ir_shift[0];
			end else begin
				state_next.tdo = sel_bsr ? state_reg.bsr_shift[0] : state_reg.bypass;
			end
		end
		if (!jtag_sel) begin
			state_next.tdo_oe = 1'b0;
		end

		// serial wire side only while the reset pin is high and the pin is enabled
		state_next.swdio_out = i_dbg_swdio_out;
		state_next.swdio_oe = state_reg.rst_s2 && state_reg.pin_en[`SWJ_PIN_SWDIO]
			&& i_dbg_swdio_oe;
		if (i_pin_enable_wr) begin
			state_next.pin_en = i_pin_enable_data;
		end

		state_next.systick_halt = state_reg.rst_s2 && i_debug_session
			&& i_core_halted;
		state_next.bp_hit = bp_match;
		state_next.wp_hit = wp_match;
		state_next.wp_trig = wp_match & i_wp_trig_en;
	end

	//--------------------------------------------------------------
	// registers
	//--------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= '0;
			state_reg.tap <= swd_jtag_pkg::TLR;
			state_reg.ir <= `SWJ_IR_BYPASS;
			state_reg.pin_en <= `SWJ_PIN_EN_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	//--------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------
	// scan pins are steered here only; no routing path reaches them
	assign o_jtag_mode = jtag_sel;
	assign o_swd_mode = state_reg.rst_s2;
	assign o_core_dbg_access_en = state_reg.rst_s2;
	assign o_swclk_func_en = state_reg.rst_s2 && state_reg.pin_en[`SWJ_PIN_SWCLK];
	assign o_swdio_func_en = state_reg.rst_s2 && state_reg.pin_en[`SWJ_PIN_SWDIO];
	assign o_swclk_rise = tck_rise && o_swclk_func_en;
	assign o_swdio_in = state_reg.tms_s2;
	assign o_swdio_out = state_reg.swdio_out;
	assign o_swdio_oe = state_reg.swdio_oe;
	// pull-ups on swclk, swdio, tdi, tms and trst are always on
	assign o_pullup_en = 1'b1;
	assign o_tdo = state_reg.tdo;
	assign o_tdo_oe = state_reg.tdo_oe;
	assign o_bsr_pins = state_reg.bsr_out;
	assign o_bsr_drive = jtag_sel && (state_reg.ir == `SWJ_IR_EXTEST);
	assign o_systick_halt = state_reg.systick_halt;
	assign o_bp_hit = state_reg.bp_hit;
	assign o_wp_hit = state_reg.wp_hit;
	assign o_wp_trigger = state_reg.wp_trig;

endmodule : swd_jtag_test_port_select
